/* File: hw/clock_switch_defines.vh */
// constants for the clock switch and idle control block
// assumes one 40 MHz clock and an axi4-lite master on the register side
`ifndef CLOCK_SWITCH_DEFINES_VH
`define CLOCK_SWITCH_DEFINES_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_REQUEST  4'h0
`define ADDR_ACTIVE   4'h4
`define ADDR_SWITCH   4'h8
`define ADDR_FREQ     4'hC
`define ADDR_POWER    5'h10
`define ADDR_IRQ_STAT 5'h14
`define ADDR_IRQ_EN   5'h18
`define ADDR_IRQ_CLR  5'h1C
// ----------------------------------------------------------------
// source encodings
// ----------------------------------------------------------------
`define SRC_EXT      3'h7
`define SRC_FAST     3'h6
`define SRC_SLOW     3'h5
`define SRC_SEC      3'h4
`define SRC_EXT_PLL  3'h2
`define DIV_MAX      4'h9
// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define RST_SRC      3'h6
`define RST_DIV      4'h0
`define RST_FREQ     4'h0
`define BIT_HOLD     7
`define BIT_SECPWR   6
`define BIT_OSCILLATOR_READY_FLAG     4
`define BIT_NEW_SOURCE_READY_FLAG    3
`define BIT_IDLE_ENABLE    0
`define BIT_DOZE_ENABLE    1
`define BIT_ROI      2
`define FLD_SRC 6:4
`define FLD_DIV 3:0
`define FLD_FREQ 3:0
`define FLD_IRQ 2:0
`define IRQ_HELD     0
`define IRQ_WAKE     1
`define IRQ_WDT      2
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

/* File: hw/clock_switch_idle.v */
// clock switch and idle control, register view over axi4-lite
// assumes oscillator ready levels arrive from other domains and are
// synchronised here; core and watchdog signals are on aclk
// every output is registered, straight from a flip-flop
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "clock_switch_defines.vh"
module clock_switch_idle (
  input wire aclk,
  input wire aresetn,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] osc_ready,
  input wire sleep_exec,
  input wire irq_pending,
  input wire wdt_timeout,
  input wire clock_output_enable_n,
  output reg [2:0] active_source_sel,
  output reg [3:0] active_divider_sel,
  output reg [3:0] fast_internal_frequency_field,
  output reg secondary_power_mode,
  output reg cpu_halt,
  output reg cpu_full_speed,
  output reg wdt_reset,
  output reg clock_out_run,
  output reg irq
);
// ----------------------------------------------------------------
// register map, one aligned word each, byte lane 0 only written
// ----------------------------------------------------------------
// 0x00 request: source code in bits 6:4, divider code in bits 3:0
// 0x04 active: source and divider now in use, read only
// 0x08 switch control: bit 7 hold, bit 6 secondary power mode,
//      bit 4 ready flag and bit 3 new source ready flag, read only
// 0x0C fast internal frequency field in bits 3:0
// 0x10 power: bit 0 idle enable, bit 1 doze, bit 2 recover on irq
// 0x14 event status, read only: held switch, irq wake, watchdog wake
// 0x18 event enables, same layout as the status
// 0x1C event clear, write one to clear, reads as zero
// anything else reads as zero with a slave error; writes answer slave error only from 0x20 up
// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [2:0] requested_source_sel; // software request
reg [3:0] requested_divider_sel; // software divider request
reg switch_hold; // hold switch at ready
reg new_source_ready_flag; // requested source ready mid switch
reg idle_enable; // sleep goes to idle
reg doze_enable; // doze mode
reg recover_on_interrupt; // interrupt restores full speed
reg idle_state; // device in idle
reg [2:0] irq_stat; // sticky events
reg [2:0] irq_en; // event enables
reg [7:0] rdy_s1; // synchroniser first stage
reg [7:0] rdy_s2; // synchroniser second stage
reg held_evt; // one cycle hold event
reg aw_got, w_got; // write halves taken
reg [5:0] aw_q; // latched write address
reg [31:0] w_q; // latched write data
reg [3:0] ws_q; // latched strobes
wire oscillator_ready_flag; // active equals requested
wire pending; // switch outstanding
wire req_rdy; // requested source ready
wire wr_go; // write performed this cycle
wire src_ok; // requested code legal
assign oscillator_ready_flag = (active_source_sel == requested_source_sel)
  && (active_divider_sel == requested_divider_sel);
assign src_ok = (requested_source_sel == `SRC_EXT) ||
  (requested_source_sel == `SRC_FAST) ||
  (requested_source_sel == `SRC_SLOW) ||
  (requested_source_sel == `SRC_SEC) ||
  (requested_source_sel == `SRC_EXT_PLL);
assign pending = !oscillator_ready_flag && src_ok;
assign req_rdy = rdy_s2[requested_source_sel];
assign wr_go = aw_got && w_got && !s_axi_bvalid;
// ----------------------------------------------------------------
// write decode and wake events
// ----------------------------------------------------------------
wire wr_low; // write that carries byte lane 0
wire wr_switch_hit; // write to switch control
wire wr_clear_hit; // write to event clear
wire wr_error; // write outside the map
wire irq_wake_evt; // interrupt ends idle this cycle
wire roi_evt; // interrupt wake that also leaves doze
assign wr_low = wr_go && ws_q[0];
assign wr_switch_hit = wr_go && (aw_q == {2'h0, `ADDR_SWITCH});
assign wr_clear_hit = wr_low && (aw_q == {1'b0, `ADDR_IRQ_CLR});
assign wr_error = {1'b0, aw_q[5:2]} > (`ADDR_IRQ_CLR >> 2);
assign irq_wake_evt = idle_state && irq_pending;
assign roi_evt = irq_wake_evt && recover_on_interrupt && doze_enable;
// ----------------------------------------------------------------
// ready synchroniser
// ----------------------------------------------------------------
// two flops per oscillator ready level
// the ready levels come from the oscillators' own domains; only
// the second stage is read, so a metastable first stage never
// reaches the switch logic
always @(posedge aclk) begin
  if (!aresetn) begin
    rdy_s1 <= 8'h00;
    rdy_s2 <= 8'h00;
  end else begin
    rdy_s1 <= osc_ready;
    rdy_s2 <= rdy_s1;
  end
end
// ----------------------------------------------------------------
// clock switch sequencing
// ----------------------------------------------------------------
// a request is only followed while its source code is legal;
// a reserved code parks the switch with the ready flag low
// ready flag set one cycle after ready, switch the cycle after that
always @(posedge aclk) begin
  if (!aresetn) begin
    active_source_sel <= `RST_SRC;
    active_divider_sel <= `RST_DIV;
    new_source_ready_flag <= 1'b0;
    held_evt <= 1'b0;
  end else begin
    // held event is a one cycle pulse
    held_evt <= 1'b0;
    // nothing outstanding: no new source ready flag
    if (!pending) begin
      new_source_ready_flag <= 1'b0;
    end else if (!new_source_ready_flag) begin
      // flag lags the ready indication by one cycle
      new_source_ready_flag <= req_rdy;
      held_evt <= req_rdy && switch_hold;
    end else if (!switch_hold) begin
      // switch in the following cycle, flag clears
      active_source_sel <= requested_source_sel;
      active_divider_sel <= requested_divider_sel;
      new_source_ready_flag <= 1'b0;
    end
  end
end
// ----------------------------------------------------------------
// idle control
// ----------------------------------------------------------------
// sleep with idle enable enters idle; interrupt or watchdog leaves
// outside idle full speed follows doze; a recovering interrupt
// forces it high on the wake edge and doze is dropped with it
always @(posedge aclk) begin
  if (!aresetn) begin
    idle_state <= 1'b0;
    cpu_halt <= 1'b0;
    cpu_full_speed <= 1'b1;
    wdt_reset <= 1'b0;
    clock_out_run <= 1'b0;
  end else begin
    wdt_reset <= wdt_timeout && !idle_state;
    clock_out_run <= !clock_output_enable_n;
    if (idle_state) begin
      if (irq_pending) begin
        // any interrupt, global enable not consulted
        idle_state <= 1'b0;
        cpu_halt <= 1'b0;
        if (recover_on_interrupt && doze_enable) begin
          cpu_full_speed <= 1'b1;
        end
      end else if (wdt_timeout) begin
        // watchdog wake, speed and doze untouched
        idle_state <= 1'b0;
        cpu_halt <= 1'b0;
      end
    end else if (sleep_exec && idle_enable) begin
      idle_state <= 1'b1;
      cpu_halt <= 1'b1;
    end else begin
      cpu_full_speed <= !doze_enable;
    end
  end
end
// ----------------------------------------------------------------
// axi write path
// ----------------------------------------------------------------
// address and data taken in either order, response after both
// awready and wready pulse for one cycle and can rise again while a
// response is owed, but a second write is only performed after bready
always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_awready <= 1'b0;
    s_axi_wready <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
    aw_got <= 1'b0;
    w_got <= 1'b0;
    aw_q <= 6'h00;
    w_q <= 32'h00000000;
    ws_q <= 4'h0;
  end else begin
    s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid;
    s_axi_wready <= !w_got && !s_axi_wready && s_axi_wvalid;
    if (s_axi_awready && s_axi_awvalid) begin
      aw_got <= 1'b1;
      aw_q <= s_axi_awaddr;
    end
    if (s_axi_wready && s_axi_wvalid) begin
      w_got <= 1'b1;
      w_q <= s_axi_wdata;
      ws_q <= s_axi_wstrb;
    end
    // both halves in hand: answer now and free the slots
    if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_axi_bresp <= wr_error ?
        `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      // response taken by the master
      s_axi_bvalid <= 1'b0;
    end
  end
end
// register writes, low byte lane only
// other lanes hold no register bits and are ignored
always @(posedge aclk) begin
  if (!aresetn) begin
    requested_source_sel <= `RST_SRC;
    requested_divider_sel <= `RST_DIV;
    switch_hold <= 1'b0;
    secondary_power_mode <= 1'b0;
    fast_internal_frequency_field <= `RST_FREQ;
    idle_enable <= 1'b0;
    doze_enable <= 1'b0;
    recover_on_interrupt <= 1'b0;
    irq_en <= 3'h0;
  end else begin
    // an interrupt that recovers from doze also ends doze, so the
    // core stays at full speed after it leaves idle
    if (roi_evt) begin
      doze_enable <= 1'b0;
    end
    if (wr_go && ws_q[0]) begin
      case (aw_q)
        {2'h0, `ADDR_REQUEST}: begin
          requested_source_sel <= w_q[`FLD_SRC];
          requested_divider_sel <= (w_q[`FLD_DIV] > `DIV_MAX) ?
            `DIV_MAX : w_q[`FLD_DIV];
        end
        {2'h0, `ADDR_SWITCH}: begin
          switch_hold <= w_q[`BIT_HOLD];
          secondary_power_mode <= w_q[`BIT_SECPWR];
        end
        {2'h0, `ADDR_FREQ}: begin
          fast_internal_frequency_field <= w_q[`FLD_FREQ];
        end
        {1'b0, `ADDR_POWER}: begin
          idle_enable <= w_q[`BIT_IDLE_ENABLE];
          doze_enable <= w_q[`BIT_DOZE_ENABLE];
          recover_on_interrupt <= w_q[`BIT_ROI];
        end
        {1'b0, `ADDR_IRQ_EN}: begin
          irq_en <= w_q[`FLD_IRQ];
        end
        default: begin
        end
      endcase
    end
    // hardware releases hold once the held switch has completed
    // a hold set while the ready flag is high and nothing is pending has nothing to wait for,
    // so it drops again in the next cycle
    if (switch_hold && oscillator_ready_flag && !held_evt &&
        new_source_ready_flag == 1'b0 && !pending &&
        !wr_switch_hit) begin
      switch_hold <= 1'b0;
    end
  end
end
// ----------------------------------------------------------------
// interrupt status
// ----------------------------------------------------------------
// set wins over clear; irq is level of enabled status
always @(posedge aclk) begin
  if (!aresetn) begin
    irq_stat <= 3'h0;
    irq <= 1'b0;
  end else begin
    // set terms go in after the clear, so an event that lands in the
    // clear cycle is kept
    irq_stat <= (irq_stat & ~(wr_clear_hit ? w_q[`FLD_IRQ] : 3'h0)) |
      {wdt_timeout && idle_state, irq_wake_evt, held_evt};
    irq <= |(irq_stat & irq_en);
  end
end
// ----------------------------------------------------------------
// axi read path
// ----------------------------------------------------------------
// one cycle to accept, data the next
// arready stays low while rvalid is up, one read at a time
// unaligned or unmapped reads answer slave error with zero data
always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `RESP_OKAY;
  end else begin
    s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    if (s_axi_arready && s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr)
        {2'h0, `ADDR_REQUEST}: s_axi_rdata <= {25'h0,
          requested_source_sel, requested_divider_sel};
        {2'h0, `ADDR_ACTIVE}: s_axi_rdata <= {25'h0,
          active_source_sel, active_divider_sel};
        {2'h0, `ADDR_SWITCH}: s_axi_rdata <= {24'h0, switch_hold,
          secondary_power_mode, 1'b0, oscillator_ready_flag,
          new_source_ready_flag, 3'h0};
        {2'h0, `ADDR_FREQ}: s_axi_rdata <= {28'h0,
          fast_internal_frequency_field};
        {1'b0, `ADDR_POWER}: s_axi_rdata <= {29'h0,
          recover_on_interrupt, doze_enable, idle_enable};
        {1'b0, `ADDR_IRQ_STAT}: s_axi_rdata <= {29'h0, irq_stat};
        {1'b0, `ADDR_IRQ_EN}: s_axi_rdata <= {29'h0, irq_en};
        {1'b0, `ADDR_IRQ_CLR}: s_axi_rdata <= 32'h00000000;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      // response taken, ready for the next address
      s_axi_rvalid <= 1'b0;
    end
  end
end
endmodule

/* File: sim/clock_switch_idle_chk.sv */
// port checker for the clock switch and idle block
// assumes it is bound onto the top module by name
`timescale 1ns/1ps
module clock_switch_idle_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] osc_ready,
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  input wire logic clock_output_enable_n,
  input wire logic [2:0] active_source_sel,
  input wire logic [3:0] active_divider_sel,
  input wire logic cpu_halt,
  input wire logic wdt_reset,
  input wire logic clock_out_run
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_src_legal;
    active_source_sel inside {3'h7, 3'h6, 3'h5, 3'h4, 3'h2};
  endproperty
  a_src_legal: assert property (p_src_legal)
    else $error("active source is reserved");
  property p_div_legal;
    active_divider_sel <= 4'h9;
  endproperty
  a_div_legal: assert property (p_div_legal)
    else $error("active divider is reserved");
  property p_switch_ready;
    $changed(active_source_sel) |-> osc_ready[active_source_sel];
  endproperty
  a_switch_ready: assert property (p_switch_ready)
    else $error("switched to a source not ready");
  property p_irq_exit;
    cpu_halt && irq_pending |-> ##[1:4] !cpu_halt;
  endproperty
  a_irq_exit: assert property (p_irq_exit)
    else $error("interrupt did not end idle");
  property p_wdt_exit;
    cpu_halt && wdt_timeout |-> ##[1:4] !cpu_halt;
  endproperty
  a_wdt_exit: assert property (p_wdt_exit)
    else $error("watchdog did not end idle");
  property p_wdt_block;
    cpu_halt && wdt_timeout |=> !wdt_reset;
  endproperty
  a_wdt_block: assert property (p_wdt_block)
    else $error("watchdog reset during idle");
  property p_wdt_cause;
    $rose(wdt_reset) |-> $past(wdt_timeout) && !$past(cpu_halt);
  endproperty
  a_wdt_cause: assert property (p_wdt_cause)
    else $error("watchdog reset without timeout");
  property p_clkout;
    (cpu_halt && !clock_output_enable_n) [*2] |-> clock_out_run;
  endproperty
  a_clkout: assert property (p_clkout)
    else $error("clock output stopped in idle");
endmodule

/* File: sim/osc_model.sv */
// oscillator sources: each ready level follows its enable late
// assumes the bench sets enable_mask just after a clock edge
`timescale 1ns/1ps
module osc_model #(
  parameter int DLY = 4
) (
  input wire logic aclk,
  input wire logic [7:0] enable_mask,
  output logic [7:0] osc_ready
);
  // ----------------------------------------
  // start-up delay line, one stage per cycle
  // ----------------------------------------
  logic [7:0] pipe [DLY];
  initial begin
    for (int i = 0; i < DLY; i++) pipe[i] = 8'h00;
  end
  // a source only reads ready some cycles after it is enabled
  always @(posedge aclk) begin
    pipe[0] <= enable_mask;
    for (int i = 1; i < DLY; i++) pipe[i] <= pipe[i-1];
  end
  assign osc_ready = pipe[DLY-1];
endmodule

/* File: sim/tb_top.sv */
// bench for the clock switch and idle block
// assumes the defines header is on the include path
`timescale 1ns/1ps
`include "clock_switch_defines.vh"
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, sleep_exec, irq_pending;
  logic wdt_timeout, clock_output_enable_n, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic secondary_power_mode, cpu_halt, cpu_full_speed, wdt_reset;
  logic clock_out_run, irq;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, active_divider_sel;
  logic [3:0] fast_internal_frequency_field;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [2:0] active_source_sel;
  logic [7:0] osc_ready, osc_mask;
  logic [2:0] codes [5] = '{3'h7, 3'h2, 3'h4, 3'h6, 3'h5};
  int miscompares, comparisons, n;
  clock_switch_idle u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .osc_ready, .sleep_exec, .irq_pending, .wdt_timeout,
    .clock_output_enable_n, .active_source_sel, .active_divider_sel,
    .fast_internal_frequency_field, .secondary_power_mode, .cpu_halt,
    .cpu_full_speed, .wdt_reset, .clock_out_run, .irq);
  osc_model u_osc (.aclk, .enable_mask(osc_mask), .osc_ready);
  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // write: both halves offered, each dropped when taken
  task automatic wr(logic [5:0] a, logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 99);
    br = s_axi_bresp;
    chk("bvalid", 1, s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdr(logic [5:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 99);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    chk("rvalid", 1, s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_src(logic [2:0] s);
    for (n = 0; n < 40 && active_source_sel !== s; n++) @(posedge aclk);
  endtask
  // sleep pulse, then wait for the halt
  task automatic sleep_in();
    sleep_exec <= 1'b1;
    @(posedge aclk);
    sleep_exec <= 1'b0;
    for (n = 0; n < 9 && cpu_halt !== 1'b1; n++) @(posedge aclk);
  endtask
  // wake by interrupt level or by one watchdog pulse
  task automatic wake(bit by_wdt);
    if (by_wdt) wdt_timeout <= 1'b1;
    else irq_pending <= 1'b1;
    @(posedge aclk);
    wdt_timeout <= 1'b0;
    for (n = 0; n < 9 && cpu_halt !== 1'b0; n++) @(posedge aclk);
    irq_pending <= 1'b0;
    @(posedge aclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("src", 3'h6, active_source_sel);
    chk("full", 1, cpu_full_speed);
    rdr(`ADDR_SWITCH);
    chk("switch ctrl", 0, rd & 32'hC0);
    rdr(`ADDR_ACTIVE);
    chk("active", 32'h60, rd);
    rdr(6'h20);
    chk("unmapped", `RESP_SLVERR, rr);
    wr(6'h20, 32'h0);
    chk("wr unmapped", `RESP_SLVERR, br);
  endtask
  task automatic t_switch();
    osc_mask <= 8'hF4;
    foreach (codes[i]) begin
      wr(`ADDR_REQUEST, {25'h0, codes[i], 4'h9});
      wait_src(codes[i]);
      chk("src", codes[i], active_source_sel);
    end
    chk("div", 4'h9, active_divider_sel);
    rdr(`ADDR_SWITCH);
    chk("ready", 32'h10, rd & 32'h18);
    wr(`ADDR_REQUEST, 32'h3F);
    repeat (20) @(posedge aclk);
    chk("reserved", 3'h5, active_source_sel);
    rdr(`ADDR_SWITCH);
    chk("not ready", 0, rd & 32'h10);
  endtask
  task automatic t_hold();
    osc_mask <= 8'hE4;
    wr(`ADDR_IRQ_EN, 32'h1);
    wr(`ADDR_SWITCH, 32'hC0);
    chk("power hi", 1, secondary_power_mode);
    wr(`ADDR_REQUEST, 32'h40);
    repeat (10) @(posedge aclk);
    chk("no irq", 0, irq);
    osc_mask <= 8'hF4;
    repeat (20) @(posedge aclk);
    chk("held", 3'h5, active_source_sel);
    chk("irq", 1, irq);
    rdr(`ADDR_SWITCH);
    chk("hold flags", 32'hC8, rd & 32'hD8);
    wr(`ADDR_SWITCH, 32'h0);
    wait_src(3'h4);
    chk("released", 3'h4, active_source_sel);
    chk("power lo", 0, secondary_power_mode);
    wr(`ADDR_IRQ_CLR, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq clr", 0, irq);
    wr(`ADDR_FREQ, 32'hA);
    chk("freq", 4'hA, fast_internal_frequency_field);
  endtask
  task automatic t_idle();
    clock_output_enable_n <= 1'b0;
    wr(`ADDR_POWER, 32'h1);
    sleep_in();
    chk("idle", 1, cpu_halt);
    chk("clkout", 1, clock_out_run);
    wake(0);
    chk("irq wake", 0, cpu_halt);
    rdr(`ADDR_POWER);
    chk("idle en", 1, rd & 32'h7);
    sleep_in();
    chk("idle again", 1, cpu_halt);
    wr(`ADDR_POWER, 32'h7);
    wake(1);
    chk("wdt wake", 0, cpu_halt);
    chk("doze kept", 0, cpu_full_speed);
    rdr(`ADDR_POWER);
    chk("doze en", 7, rd & 32'h7);
    sleep_in();
    wake(0);
    chk("recover", 1, cpu_full_speed);
    rdr(`ADDR_POWER);
    chk("doze cleared", 5, rd & 32'h7);
    rdr(`ADDR_IRQ_STAT);
    chk("wake status", 6, rd & 32'h7);
    wdt_timeout <= 1'b1;
    @(posedge aclk);
    wdt_timeout <= 1'b0;
    @(posedge aclk);
    chk("wdt reset", 1, wdt_reset);
  endtask
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    conclude();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, sleep_exec, irq_pending} = '0;
    {wdt_timeout, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    clock_output_enable_n = 1'b1;
    s_axi_wstrb = 4'hF;
    osc_mask = 8'h40;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_switch();
    t_hold();
    t_idle();
    conclude();
  end
endmodule
bind clock_switch_idle clock_switch_idle_chk u_chk (.aclk(aclk),
  .aresetn(aresetn), .osc_ready(osc_ready), .irq_pending(irq_pending),
  .wdt_timeout(wdt_timeout), .clock_output_enable_n(clock_output_enable_n),
  .active_source_sel(active_source_sel), .cpu_halt(cpu_halt),
  .active_divider_sel(active_divider_sel), .wdt_reset(wdt_reset),
  .clock_out_run(clock_out_run));
